// *** cps_pkg.sv ***
// constants and types for the cpu state block: vectors, status word fields, stack figures
package cps_pkg;
  // ----------------------------------------------------------------
  // program counter vectors
  // ----------------------------------------------------------------
  localparam logic [31:0] CPS_RESET_VECTOR  = 32'h0000_8000; // reset or watchdog
  localparam logic [31:0] CPS_EXCEPT_VECTOR = 32'h0000_8080; // exception processing
  localparam logic [31:0] CPS_VECTOR_STEP   = 32'h0000_0004; // spacing of group vectors
  localparam int          CPS_IRQ_GROUPS    = 15;            // groups above the base
  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int CPS_LOW_BYTE_ZERO_BIT = 0;
  localparam int CPS_WORD_ZERO_BIT     = 1;
  localparam int CPS_CARRY_BIT         = 2;
  localparam int CPS_HALF_CARRY_BIT    = 3;
  localparam int CPS_OVERFLOW_BIT      = 4;
  localparam int CPS_PARITY_BIT        = 5;
  localparam int CPS_SIGN_BIT          = 6;
  localparam int CPS_IRQ_ALLOW_BIT     = 7;
  localparam int CPS_IRQ_LEVEL_LSB     = 8;
  localparam int CPS_IRQ_LEVEL_MSB     = 10;
  localparam int CPS_WRITE_GATE_BIT    = 11;
  localparam int CPS_REG_INDEX_LSB     = 12;
  localparam int CPS_REG_INDEX_MSB     = 15;
  localparam logic [15:0] CPS_STATE_RESET = 16'h0000; // status word after reset
  // ----------------------------------------------------------------
  // register file and stack
  // ----------------------------------------------------------------
  localparam int          CPS_NUM_REGS      = 16;
  localparam logic [3:0]  CPS_STATUS_REG    = 4'he;    // status alias register
  localparam logic [3:0]  CPS_STACK_REG     = 4'hf;    // stack alias register
  localparam logic [3:0]  CPS_BASE_REG_A    = 4'h8;
  localparam logic [3:0]  CPS_BASE_REG_B    = 4'h9;
  localparam logic [15:0] CPS_STACK_STEP    = 16'h0002; // word step of the stack
  localparam logic [31:0] CPS_INSN_BYTES    = 32'h0000_0002;
  localparam logic [31:0] CPS_RAM_BASE      = 32'h0000_0000;
  localparam logic [31:0] CPS_RAM_LAST      = 32'h0000_5fff; // 24576 bytes
  // ----------------------------------------------------------------
  // operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CPS_OP_NONE, CPS_OP_REG_WRITE, CPS_OP_ALU, CPS_OP_MULDIV, CPS_OP_SHIFT,
    CPS_OP_FAR_JUMP, CPS_OP_REG_JUMP, CPS_OP_REL12, CPS_OP_REL_REG, CPS_OP_COND,
    CPS_OP_FAR_CALL, CPS_OP_REG_CALL, CPS_OP_REL_CALL, CPS_OP_REL_REG_CALL,
    CPS_OP_PUSH, CPS_OP_POP, CPS_OP_RETURN, CPS_OP_IRQ_RETURN,
    CPS_OP_IRQ_ACCEPT, CPS_OP_EXCEPTION
  } cps_op_type;
  typedef enum {
    CPS_ST_IDLE, CPS_ST_PUSH_LOW, CPS_ST_PUSH_HIGH, CPS_ST_PUSH_STATE,
    CPS_ST_PUSH_DATA, CPS_ST_POP_DATA, CPS_ST_POP_STATE, CPS_ST_POP_HIGH,
    CPS_ST_POP_LOW
  } cps_state_type;
endpackage

// *** cps_flag_calc.sv ***
// status flag evaluation of one result word
`timescale 1ns/100ps
module cps_flag_calc
  import cps_pkg::*;
(
  // result in
  input  wire logic [15:0] result,
  input  wire logic        byte_mode,
  // flags out
  output logic             low_byte_zero_flag,
  output logic             word_zero_flag,
  output logic             parity_flag,
  output logic             sign_flag
);
  // zero, parity and sign taken on byte or word width
  always_comb begin
    low_byte_zero_flag = (result[7:0] == 8'h00);
    word_zero_flag     = byte_mode ? low_byte_zero_flag : (result == 16'h0000);
    parity_flag        = byte_mode ? ^result[7:0] : ^result;
    sign_flag          = byte_mode ? result[7] : result[15];
  end
endmodule

// *** cps_core_state.sv ***
// program counter, general registers, status word and stack sequencing of the core
`timescale 1ns/100ps
module cps_core_state
  import cps_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // operation request
  input  wire cps_op_type  op,            // one-cycle operation strobe
  input  wire logic [3:0]  dst_index,     // target register
  input  wire logic [3:0]  src_index,     // source register for jumps
  input  wire logic        base_sel_b,    // 1 picks base register b
  input  wire logic        byte_mode,     // byte-wide operation
  input  wire logic [15:0] wr_data,       // result or push data
  input  wire logic        carry_in,      // carry out of bit 15
  input  wire logic        half_carry_in, // carry out of bit 3
  input  wire logic        overflow_in,   // arithmetic overflow
  input  wire logic        signed_div,    // signed divide variant
  input  wire logic [31:0] far_target,    // 32-bit absolute target
  input  wire logic [11:0] disp12,        // 12-bit displacement
  input  wire logic [7:0]  disp8,         // 8-bit displacement
  input  wire logic        disp_short,    // use 8-bit displacement
  input  wire logic [31:0] insn_bytes,    // byte count of the branch
  input  wire logic        branch_taken,  // condition met
  input  wire logic [3:0]  irq_group,     // group 0..14 above base
  // interrupt level check
  input  wire logic [2:0]  irq_req_level,
  output logic             irq_acceptable,
  output logic             exc_ctrl_write_ok,
  // ram port
  output logic [31:0]      ram_addr,
  output logic             ram_wr,
  output logic             ram_rd,
  output logic [15:0]      ram_wdata,
  input  wire logic [15:0] ram_rdata,
  output logic             ram_range_hit,
  // state view
  output logic             busy,
  output logic [31:0]      pc,
  output logic [15:0]      cpu_state_word,
  output logic [15:0]      pop_data,
  input  wire logic [3:0]  rd_index,
  output logic [15:0]      rd_data
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0]   pc_q;                     // program counter
  logic [31:0]   pc_d;                     // next counter value
  logic [15:0]   regs_q [CPS_NUM_REGS];    // general registers
  logic [15:0]   psw_q;                    // status word, kept apart from regs_q
  logic          save_state_q;             // call also saves the status word
  cps_state_type state_q;                  // stack sequencer
  logic [31:0]   ret_pc_q;                 // return address to save
  logic [31:0]   ret_target_q;             // target after the pushes
  logic [15:0]   pop_data_q;               // last popped word
  logic [15:0]   pop_high_q;               // popped high half
  logic          stk_wr_q;                 // ram write strobe
  logic          stk_rd_q;                 // ram read strobe
  logic [15:0]   stk_addr_q;               // ram address
  logic [15:0]   stk_wdata_q;              // ram write data
  // ----------------------------------------------------------------
  // views of the register file
  // ----------------------------------------------------------------
  logic [15:0] sp;                         // stack alias register
  logic [15:0] processor_status_word;                        // status alias register
  logic [15:0] base_val;                   // chosen base register
  logic [15:0] src_val;                    // source register
  logic        fz8, fz16, fpar, fsign;     // flags of the result
  logic [15:0] load_val;                   // value as written
  assign sp       = regs_q[CPS_STACK_REG];
  // the status alias index reads the separate status register
  assign processor_status_word      = psw_q;
  assign base_val = base_sel_b ? regs_q[CPS_BASE_REG_B] : regs_q[CPS_BASE_REG_A];
  assign src_val  = (src_index == CPS_STATUS_REG) ? psw_q : regs_q[src_index];
  assign load_val = byte_mode ? {8'h00, wr_data[7:0]} : wr_data;
  // flag evaluation of the incoming result
  cps_flag_calc u_flags (
    .result             (wr_data),
    .byte_mode          (byte_mode),
    .low_byte_zero_flag (fz8),
    .word_zero_flag     (fz16),
    .parity_flag        (fpar),
    .sign_flag          (fsign)
  );
  // ----------------------------------------------------------------
  // branch targets
  // ----------------------------------------------------------------
  logic [31:0] rel12_t, relreg_t, cond_t, reg_t, vec_t;
  logic [31:0] disp_cond;                  // sign-extended condition offset
  always_comb begin
    reg_t     = {base_val, src_val};
    rel12_t   = pc_q + CPS_INSN_BYTES + {{20{disp12[11]}}, disp12};
    relreg_t  = pc_q + CPS_INSN_BYTES + {{16{src_val[15]}}, src_val};
    disp_cond = disp_short ? {{24{disp8[7]}}, disp8} : {{20{disp12[11]}}, disp12};
    cond_t    = pc_q + insn_bytes + disp_cond;
    vec_t     = CPS_RESET_VECTOR + CPS_VECTOR_STEP * ({28'h0, irq_group} + 32'h1);
  end
  // next program counter: direct ops while idle, call and return targets at the end of a stack sequence
  always_comb begin
    pc_d = pc_q;
    if (state_q == CPS_ST_IDLE) begin
      case (op)
        // absolute and register targets
        CPS_OP_FAR_JUMP:     pc_d = far_target;
        CPS_OP_REG_JUMP:     pc_d = reg_t;
        // relative forms
        CPS_OP_REL12:        pc_d = rel12_t;
        CPS_OP_REL_REG:      pc_d = relreg_t;
        // conditional: target or fall through
        CPS_OP_COND:         pc_d = branch_taken ? cond_t : pc_q + insn_bytes;
        // exception entry
        CPS_OP_EXCEPTION:    pc_d = CPS_EXCEPT_VECTOR;
        default:             pc_d = pc_q;
      endcase
    end else if (state_q == CPS_ST_PUSH_HIGH && !save_state_q) begin
      // plain call: jump after the high half
      pc_d = ret_target_q;
    end else if (state_q == CPS_ST_PUSH_STATE) begin
      // state-saving call or irq: jump after the state word
      pc_d = ret_target_q;
    end else if (state_q == CPS_ST_POP_LOW) begin
      // return: both halves back in place
      pc_d = {pop_high_q, ram_rdata};
    end
  end
  // program counter register, bit zero held low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pc_q <= CPS_RESET_VECTOR;
    end else begin
      pc_q <= {pc_d[31:1], 1'b0};
    end
  end
  // ----------------------------------------------------------------
  // stack sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // idle, nothing saved
      state_q      <= CPS_ST_IDLE;
      save_state_q <= 1'b0;
      ret_pc_q     <= 32'h0;
      ret_target_q <= 32'h0;
      pop_high_q   <= 16'h0;
    end else begin
      case (state_q)
        CPS_ST_IDLE: begin
          // calls return past the call itself
          ret_pc_q <= pc_q + CPS_INSN_BYTES;
          case (op)
            // calls: pick the target now, jump after the pushes
            CPS_OP_FAR_CALL, CPS_OP_REG_CALL, CPS_OP_REL_CALL,
            CPS_OP_REL_REG_CALL: begin
              state_q      <= CPS_ST_PUSH_LOW;
              // byte mode marks the irq-style call
              save_state_q <= byte_mode;
              ret_target_q <= (op == CPS_OP_FAR_CALL) ? far_target :
                              (op == CPS_OP_REG_CALL) ? reg_t :
                              (op == CPS_OP_REL_CALL) ? rel12_t : relreg_t;
            end
            // irq accept saves the current counter
            CPS_OP_IRQ_ACCEPT: begin
              state_q      <= CPS_ST_PUSH_LOW;
              save_state_q <= 1'b1;
              ret_pc_q     <= pc_q;
              ret_target_q <= vec_t;
            end
            // single word and return sequences
            CPS_OP_PUSH:       state_q <= CPS_ST_PUSH_DATA;
            CPS_OP_POP:        state_q <= CPS_ST_POP_DATA;
            CPS_OP_RETURN:     state_q <= CPS_ST_POP_HIGH;
            CPS_OP_IRQ_RETURN: state_q <= CPS_ST_POP_STATE;
            default:           state_q <= CPS_ST_IDLE;
          endcase
        end
        // push chain: low, high, optional state
        CPS_ST_PUSH_LOW:   state_q <= CPS_ST_PUSH_HIGH;
        CPS_ST_PUSH_HIGH:  state_q <= save_state_q ? CPS_ST_PUSH_STATE : CPS_ST_IDLE;
        CPS_ST_PUSH_STATE: state_q <= CPS_ST_IDLE;
        CPS_ST_PUSH_DATA:  state_q <= CPS_ST_IDLE;
        CPS_ST_POP_DATA:   state_q <= CPS_ST_IDLE;
        // pop chain: state, high, low
        CPS_ST_POP_STATE:  state_q <= CPS_ST_POP_HIGH;
        CPS_ST_POP_HIGH: begin
          state_q    <= CPS_ST_POP_LOW;
          pop_high_q <= ram_rdata;
        end
        CPS_ST_POP_LOW:    state_q <= CPS_ST_IDLE;
        default:           state_q <= CPS_ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // ram strobes: address, data and reads, one cycle each
  // ----------------------------------------------------------------
  always_comb begin
    stk_wr_q    = 1'b0;
    stk_rd_q    = 1'b0;
    stk_addr_q  = sp;
    stk_wdata_q = 16'h0;
    case (state_q)
      // pushes write at the pointer
      CPS_ST_PUSH_LOW:   begin stk_wr_q = 1'b1; stk_wdata_q = ret_pc_q[15:0];  end
      CPS_ST_PUSH_HIGH:  begin stk_wr_q = 1'b1; stk_wdata_q = ret_pc_q[31:16]; end
      CPS_ST_PUSH_STATE: begin stk_wr_q = 1'b1; stk_wdata_q = processor_status_word;             end
      CPS_ST_PUSH_DATA:  begin stk_wr_q = 1'b1; stk_wdata_q = wr_data;         end
      // pops read one word below it
      CPS_ST_POP_DATA, CPS_ST_POP_STATE, CPS_ST_POP_HIGH, CPS_ST_POP_LOW: begin
        stk_rd_q   = 1'b1;
        stk_addr_q = sp - CPS_STACK_STEP;
      end
      default: stk_wr_q = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // register file and status word
  // ----------------------------------------------------------------
  logic        is_push, is_pop;
  assign is_push = (state_q == CPS_ST_PUSH_LOW) || (state_q == CPS_ST_PUSH_HIGH) ||
                   (state_q == CPS_ST_PUSH_STATE) || (state_q == CPS_ST_PUSH_DATA);
  assign is_pop  = stk_rd_q;
  // general registers 0..13 and the stack pointer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < CPS_NUM_REGS; i++) begin
        regs_q[i] <= 16'h0000;
      end
    end else begin
      // pointer walks with each stack word
      if (is_push) begin
        regs_q[CPS_STACK_REG] <= sp + CPS_STACK_STEP;
      end else if (is_pop) begin
        regs_q[CPS_STACK_REG] <= sp - CPS_STACK_STEP;
      end
      // popped data word
      if (state_q == CPS_ST_POP_DATA) pop_data_q <= ram_rdata;
      // result write; status index and muldiv into the pointer excluded
      if (state_q == CPS_ST_IDLE && (op == CPS_OP_REG_WRITE || op == CPS_OP_ALU ||
          op == CPS_OP_SHIFT || op == CPS_OP_MULDIV) && dst_index != CPS_STATUS_REG &&
          !(op == CPS_OP_MULDIV && dst_index == CPS_STACK_REG)) begin
        regs_q[dst_index] <= load_val;
      end
    end
  end
  // status word register, one process of its own
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // flags, level and index clear
      psw_q <= CPS_STATE_RESET;
    end else if (state_q == CPS_ST_POP_STATE) begin
      // irq return restores the saved word
      psw_q <= ram_rdata;
    end else if (state_q == CPS_ST_IDLE) begin
      case (op)
        // transfers, arithmetic and shifts
        CPS_OP_REG_WRITE, CPS_OP_ALU, CPS_OP_SHIFT: begin
          if (dst_index == CPS_STATUS_REG) begin
            // direct write of the status word
            psw_q <= load_val;
          end else begin
            // zero, parity, sign and register index
            psw_q[CPS_LOW_BYTE_ZERO_BIT] <= fz8;
            psw_q[CPS_WORD_ZERO_BIT]     <= fz16;
            psw_q[CPS_PARITY_BIT]        <= fpar;
            psw_q[CPS_SIGN_BIT]          <= fsign;
            psw_q[CPS_REG_INDEX_MSB:CPS_REG_INDEX_LSB] <= dst_index;
            // carry only from alu and shifts
            if (op != CPS_OP_REG_WRITE) begin
              psw_q[CPS_CARRY_BIT] <= carry_in;
            end
            // half carry and overflow only from alu
            if (op == CPS_OP_ALU) begin
              psw_q[CPS_HALF_CARRY_BIT] <= half_carry_in;
              psw_q[CPS_OVERFLOW_BIT]   <= overflow_in;
            end
          end
        end
        // multiply and divide: result flags, carry from a signed sign, half carry, overflow and index cleared
        CPS_OP_MULDIV: begin
          psw_q[CPS_LOW_BYTE_ZERO_BIT] <= fz8;
          psw_q[CPS_WORD_ZERO_BIT]     <= fz16;
          psw_q[CPS_PARITY_BIT]        <= fpar;
          psw_q[CPS_SIGN_BIT]          <= fsign;
          psw_q[CPS_HALF_CARRY_BIT]    <= 1'b0;
          psw_q[CPS_OVERFLOW_BIT]      <= 1'b0;
          psw_q[CPS_REG_INDEX_MSB:CPS_REG_INDEX_LSB] <= 4'h0;
          psw_q[CPS_CARRY_BIT]         <= signed_div & fsign;
        end
        // everything else leaves the word alone
        default: psw_q <= psw_q;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // interrupt and write gate views
  assign irq_acceptable    = processor_status_word[CPS_IRQ_ALLOW_BIT] &&
                             (irq_req_level > processor_status_word[CPS_IRQ_LEVEL_MSB:CPS_IRQ_LEVEL_LSB]);
  assign exc_ctrl_write_ok = processor_status_word[CPS_WRITE_GATE_BIT];
  // ram port
  assign ram_addr          = {16'h0000, stk_addr_q[15:1], 1'b0};
  assign ram_wr            = stk_wr_q;
  assign ram_rd            = stk_rd_q;
  assign ram_wdata         = stk_wdata_q;
  assign ram_range_hit     = (ram_addr >= CPS_RAM_BASE) && (ram_addr <= CPS_RAM_LAST);
  // state view
  assign busy              = (state_q != CPS_ST_IDLE);
  assign pc                = pc_q;
  assign cpu_state_word    = processor_status_word;
  assign pop_data          = pop_data_q;
  assign rd_data           = (rd_index == CPS_STATUS_REG) ? psw_q : regs_q[rd_index];
endmodule

// *** cps_ram_model.sv ***
// word-wide stack and data ram at the far side of the ram port
`timescale 1ns/100ps
module cps_ram_model (
  // clock
  input  wire logic        clk,
  // ram port
  input  wire logic [31:0] ram_addr,
  input  wire logic        ram_wr,
  input  wire logic        ram_rd,
  input  wire logic [15:0] ram_wdata,
  output logic      [15:0] ram_rdata
);
  logic [15:0] mem [0:12287]; // 24576 bytes held as words
  logic [15:0] last_q;        // last word shown on the read lines
  // word write inside the mapped range only
  always_ff @(posedge clk) begin
    if (ram_wr && ram_addr <= 32'h0000_5fff) begin
      mem[ram_addr[14:1]] <= ram_wdata;
    end
    if (ram_rd) begin
      last_q <= ram_rdata;
    end
  end
  // same-cycle read; released lines carry the inverse of the last word
  always_comb begin
    if (ram_rd && ram_addr <= 32'h0000_5fff) begin
      ram_rdata = mem[ram_addr[14:1]];
    end else begin
      ram_rdata = ~last_q;
    end
  end
endmodule

// *** cps_core_state_assertions.sv ***
// concurrent checks on the ports of the core state block
`timescale 1ns/100ps
module cps_core_state_assertions
  import cps_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // request side
  input wire cps_op_type  op,
  input wire logic        byte_mode,
  input wire logic [15:0] wr_data,
  input wire logic [31:0] far_target,
  input wire logic [2:0]  irq_req_level,
  // answer side
  input wire logic        irq_acceptable,
  input wire logic        exc_ctrl_write_ok,
  input wire logic [31:0] ram_addr,
  input wire logic        ram_wr,
  input wire logic        ram_rd,
  input wire logic [15:0] ram_wdata,
  input wire logic [15:0] ram_rdata,
  input wire logic        ram_range_hit,
  input wire logic        busy,
  input wire logic [31:0] pc,
  input wire logic [15:0] cpu_state_word,
  input wire logic [15:0] pop_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pc_bit_zero: assert property (pc[0] == 1'b0) else $error("pc bit zero set");
  a_reset_vector_load: assert property ($rose(rst_b) |-> pc == CPS_RESET_VECTOR)
    else $error("pc not at reset vector");
  a_irq_level_gate: assert property (irq_acceptable == (cpu_state_word[7]
    && irq_req_level > cpu_state_word[10:8])) else $error("irq accept wrong");
  a_write_gate_follow: assert property (exc_ctrl_write_ok == cpu_state_word[11])
    else $error("write gate wrong");
  a_ram_range_flag: assert property (ram_range_hit == (ram_addr <= 32'h0000_5fff))
    else $error("range flag wrong");
  a_push_word_walk: assert property (!busy && op == CPS_OP_PUSH |=> busy && ram_wr
    && ram_wdata == $past(wr_data) ##1 !busy) else $error("push walk wrong");
  a_pop_word_walk: assert property (!busy && op == CPS_OP_POP |=> ram_rd
    ##1 !busy && pop_data == $past(ram_rdata)) else $error("pop walk wrong");
  a_irq_call_pushes: assert property (!busy && op == CPS_OP_FAR_CALL && byte_mode
    |=> ram_wr [*3] ##1 !busy && pc == ($past(far_target, 4) & 32'hffff_fffe))
    else $error("irq-style call wrong");
  a_return_pops: assert property (!busy && op == CPS_OP_RETURN |=> ram_rd [*2]
    ##1 !busy) else $error("return walk wrong");
  a_exception_load: assert property (!busy && op == CPS_OP_EXCEPTION
    |-> ##[1:4] pc == CPS_EXCEPT_VECTOR) else $error("exception vector missing");
  // main scenarios reached
  c_push: cover property (!busy && op == CPS_OP_PUSH);
  c_irq_call: cover property (!busy && op == CPS_OP_FAR_CALL && byte_mode);
  c_irq_accept: cover property (!busy && op == CPS_OP_IRQ_ACCEPT);
endmodule
bind cps_core_state cps_core_state_assertions u_chk (.clk(clk), .rst_b(rst_b), .op(op),
  .byte_mode(byte_mode), .wr_data(wr_data), .far_target(far_target),
  .irq_req_level(irq_req_level), .irq_acceptable(irq_acceptable),
  .exc_ctrl_write_ok(exc_ctrl_write_ok), .ram_addr(ram_addr), .ram_wr(ram_wr),
  .ram_rd(ram_rd), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
  .ram_range_hit(ram_range_hit), .busy(busy), .pc(pc),
  .cpu_state_word(cpu_state_word), .pop_data(pop_data));

// *** test_cpu_pc_regfile_stack.sv ***
// self-checking bench for the core state block
`timescale 1ns/100ps
module test_cpu_pc_regfile_stack;
  import cps_pkg::*;
  // ----------------------------------------------------------------
  // design inputs and outputs
  // ----------------------------------------------------------------
  logic        clk, rst_b, base_sel_b, byte_mode, carry_in, half_carry_in, overflow_in;
  logic        signed_div, disp_short, branch_taken, irq_acceptable, exc_ctrl_write_ok;
  logic        ram_wr, ram_rd, ram_range_hit, busy;
  cps_op_type  op;
  logic [3:0]  dst_index, src_index, irq_group, rd_index;
  logic [2:0]  irq_req_level;
  logic [7:0]  disp8;
  logic [11:0] disp12;
  logic [15:0] wr_data, ram_wdata, ram_rdata, cpu_state_word, pop_data, rd_data;
  logic [31:0] far_target, insn_bytes, ram_addr, pc, epc;
  int          num_errors, comparisons;
  always #20 clk = ~clk; // 25 MHz
  cps_core_state dut (.clk(clk), .rst_b(rst_b), .op(op), .dst_index(dst_index),
    .src_index(src_index), .base_sel_b(base_sel_b), .byte_mode(byte_mode),
    .wr_data(wr_data), .carry_in(carry_in), .half_carry_in(half_carry_in),
    .overflow_in(overflow_in), .signed_div(signed_div), .far_target(far_target),
    .disp12(disp12), .disp8(disp8), .disp_short(disp_short), .insn_bytes(insn_bytes),
    .branch_taken(branch_taken), .irq_group(irq_group), .irq_req_level(irq_req_level),
    .irq_acceptable(irq_acceptable), .exc_ctrl_write_ok(exc_ctrl_write_ok),
    .ram_addr(ram_addr), .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .ram_range_hit(ram_range_hit), .busy(busy), .pc(pc),
    .cpu_state_word(cpu_state_word), .pop_data(pop_data), .rd_index(rd_index),
    .rd_data(rd_data));
  cps_ram_model u_ram (.clk(clk), .ram_addr(ram_addr), .ram_wr(ram_wr), .ram_rd(ram_rd),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one-cycle strobe at a falling edge, then a bounded wait for idle
  task automatic run(input cps_op_type o);
    int n;
    op = o;
    @(negedge clk);
    op = CPS_OP_NONE;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      chk(1, 0, "busy stuck");
      finish_test();
    end
  endtask
  // register write and register compare
  task automatic wreg(input logic [3:0] i, input logic [15:0] v, input logic bm);
    dst_index = i;
    wr_data = v;
    byte_mode = bm;
    run(CPS_OP_REG_WRITE);
    byte_mode = 1'b0;
  endtask
  task automatic rchk(input logic [3:0] i, input logic [15:0] exp, input string what);
    rd_index = i;
    #1 chk(rd_data, exp, what);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, rst_b, base_sel_b, byte_mode, carry_in, half_carry_in, overflow_in} = '0;
    {signed_div, disp_short, branch_taken, dst_index, src_index, irq_group} = '0;
    {rd_index, irq_req_level, disp8, disp12, wr_data, far_target} = '0;
    {num_errors, comparisons} = '0;
    insn_bytes = 32'h0000_0002;
    op = CPS_OP_NONE;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    chk(pc, CPS_RESET_VECTOR, "reset pc");
    chk(cpu_state_word, CPS_STATE_RESET, "reset state word");
    $display("test reset done");
    wreg(4'hf, 16'h0100, 1'b0);
    wreg(4'h3, 16'habcd, 1'b1);
    rchk(4'h3, 16'h00cd, "byte load");
    wreg(4'h9, 16'h0002, 1'b0);
    wreg(4'h4, 16'hfff0, 1'b0);
    dst_index = 4'h5;
    wr_data = 16'h8100;
    carry_in = 1'b1;
    overflow_in = 1'b1;
    run(CPS_OP_ALU);
    chk(cpu_state_word, 16'h5055, "alu flags");
    {dst_index, wr_data, carry_in, signed_div} = {4'h0, 16'h8000, 1'b0, 1'b1};
    run(CPS_OP_MULDIV);
    chk(cpu_state_word, 16'h0065, "muldiv flags");
    wreg(4'he, 16'h0b80, 1'b0);
    irq_req_level = 3'h3;
    #1 chk(irq_acceptable, 0, "level equal");
    irq_req_level = 3'h4;
    #1 chk(irq_acceptable, 1, "level above");
    chk(exc_ctrl_write_ok, 1, "write gate");
    $display("test registers and flags done");
    far_target = 32'h0001_2345;
    run(CPS_OP_FAR_JUMP);
    chk(pc, 32'h0001_2344, "far jump");
    disp12 = 12'h800;
    epc = 32'h0001_2344 + 32'd2 - 32'd2048;
    run(CPS_OP_REL12);
    chk(pc, epc, "relative 12");
    {disp8, disp_short, insn_bytes, branch_taken} = {8'h7e, 1'b1, 32'h4, 1'b1};
    epc = epc + 32'd4 + 32'd126;
    run(CPS_OP_COND);
    chk(pc, epc, "taken branch");
    {src_index, base_sel_b} = {4'h3, 1'b1};
    run(CPS_OP_REG_JUMP);
    chk(pc, 32'h0002_00cc, "register jump");
    src_index = 4'h4;
    epc = 32'h0002_00cc + 32'd2 - 32'd16;
    run(CPS_OP_REL_REG);
    chk(pc, epc, "register relative");
    $display("test branches done");
    wr_data = 16'h1234;
    run(CPS_OP_PUSH);
    chk(u_ram.mem[16'h0080], 16'h1234, "pushed word");
    rchk(4'hf, 16'h0102, "sp after push");
    run(CPS_OP_POP);
    chk(pop_data, 16'h1234, "popped word");
    rchk(4'hf, 16'h0100, "sp after pop");
    wreg(4'he, 16'h0b80, 1'b0);
    {far_target, byte_mode} = {32'h0000_9000, 1'b1};
    run(CPS_OP_FAR_CALL);
    byte_mode = 1'b0;
    chk(u_ram.mem[16'h0080], epc[15:0] + 16'h2, "call low half");
    chk(u_ram.mem[16'h0081], epc[31:16], "call high half");
    chk(u_ram.mem[16'h0082], 16'h0b80, "call state word");
    rchk(4'hf, 16'h0106, "sp after call");
    chk(pc, 32'h0000_9000, "call target");
    wreg(4'he, 16'h0000, 1'b0);
    run(CPS_OP_IRQ_RETURN);
    chk(pc, epc + 32'd2, "irq return pc");
    chk(cpu_state_word, 16'h0b80, "irq return state");
    rchk(4'hf, 16'h0100, "sp after irq return");
    irq_group = 4'he;
    run(CPS_OP_IRQ_ACCEPT);
    chk(pc, CPS_RESET_VECTOR + CPS_VECTOR_STEP * 32'd15, "group vector");
    chk(u_ram.mem[16'h0080], epc[15:0] + 16'h2, "accept low half");
    rchk(4'hf, 16'h0106, "sp after accept");
    run(CPS_OP_EXCEPTION);
    chk(pc, CPS_EXCEPT_VECTOR, "exception vector");
    far_target = 32'h0000_a000;
    run(CPS_OP_FAR_CALL);
    chk(pc, 32'h0000_a000, "plain call target");
    rchk(4'hf, 16'h010a, "sp after plain call");
    run(CPS_OP_RETURN);
    chk(pc, CPS_EXCEPT_VECTOR + 32'd2, "return pc");
    rchk(4'hf, 16'h0106, "sp after return");
    $display("test stack done");
    finish_test();
  end
endmodule
